// File: pkg/udb_params.svh
`ifndef UDB_PARAMS_SVH
`define UDB_PARAMS_SVH

// ************************************************************
// timing
// ************************************************************
`define UDB_CLK_NS     8
`define UDB_SS_NS      50
`define UDB_RP_NS_M0   160
`define UDB_RP_NS_M1   125
`define UDB_RP_NS_M2   100
`define UDB_RP_NS_M3   100
`define UDB_RP_NS_M4   100
`define UDB_RP_NS_M5   85
`define UDB_ENV_CYC    8'h04
`define UDB_HALF_CYC   8'h0A
`define UDB_SETUP_CYC  8'h02
`define UDB_HOLD_CYC   8'h04

// ************************************************************
// crc, polarity and idle levels
// ************************************************************
`define UDB_CRC_SEED   16'h4ABA
`define UDB_CRC_POLY   16'h1021
`define UDB_RQ_LVL_IDE 1'b1
`define UDB_RQ_LVL_PC  1'b1
`define UDB_AK_LVL_IDE 1'b0
`define UDB_AK_LVL_PC  1'b0
`define UDB_LINE_IDLE  1'b1
`define UDB_BUS_IDLE   16'hFFFF
`endif

// File: pkg/udb_pkg.sv
package udb_pkg;
`include "udb_params.svh"

   typedef logic [2:0] udb_mode_t;

   typedef enum logic [2:0] {D_IDLE, D_REQ, D_IN, D_SS, D_OUT, D_END} udb_dev_state_t;
   typedef enum logic [2:0] {H_IDLE, H_ENV, H_IN, H_OUT, H_SS, H_WAIT, H_CRC,
                             H_HOLD} udb_host_state_t;

   // device end state
   typedef struct packed {
      udb_dev_state_t st;
      logic           ak1, ak2, sp1, sp2, hl1, hl2, hl3;
      logic [15:0]    d1, d2;
      logic           dir, rq, drl, drl_oe;
      logic [15:0]    dd;
      logic           dd_oe;
      logic [7:0]     cnt;
      logic           pend;
      logic [15:0]    crc, rxd;
      logic           txr, rxv, err, done, busy;
   } udb_dev_st_t;

   // host end state
   typedef struct packed {
      udb_host_state_t st;
      logic            rq1, rq2, dl1, dl2, dl3;
      logic [15:0]     d1, d2;
      logic            dir, ak, stp, hrl;
      logic [15:0]     hd;
      logic            hd_oe;
      logic [7:0]      cnt;
      logic            pend;
      logic [15:0]     crc, rxd;
      logic            txr, rxv, done, busy;
   } udb_host_st_t;

   // nanoseconds to cycles, rounded up
   function automatic logic [7:0] udb_ns2cyc(input int ns);
      int c;
      c = (ns + `UDB_CLK_NS - 1) / `UDB_CLK_NS;
      return c[7:0];
   endfunction : udb_ns2cyc

   // ready-to-pause cycles per transfer mode
   function automatic logic [7:0] udb_rp_cyc(input udb_mode_t m);
      logic [7:0] c;
      case (m)
         3'h0: c = udb_ns2cyc(`UDB_RP_NS_M0);
         3'h1: c = udb_ns2cyc(`UDB_RP_NS_M1);
         3'h2: c = udb_ns2cyc(`UDB_RP_NS_M2);
         3'h3: c = udb_ns2cyc(`UDB_RP_NS_M3);
         3'h4: c = udb_ns2cyc(`UDB_RP_NS_M4);
         3'h5: c = udb_ns2cyc(`UDB_RP_NS_M5);
         default: c = udb_ns2cyc(`UDB_RP_NS_M0);
      endcase
      return c;
   endfunction : udb_rp_cyc

   // asserted level of request (ack=0) or acknowledge (ack=1)
   function automatic logic udb_lvl(input logic pc, input logic ack);
      if (ack) begin
         return pc ? `UDB_AK_LVL_PC : `UDB_AK_LVL_IDE;
      end
      return pc ? `UDB_RQ_LVL_PC : `UDB_RQ_LVL_IDE;
   endfunction : udb_lvl

   // pin level for an asserted or negated line
   function automatic logic udb_pin(input logic pc, input logic ack, input logic on);
      return on ? udb_lvl(pc, ack) : ~udb_lvl(pc, ack);
   endfunction : udb_pin

   // is the pin level asserted
   function automatic logic udb_on(input logic pc, input logic ack, input logic pin);
      return pin == udb_lvl(pc, ack);
   endfunction : udb_on

   // burst crc over one word, msb first
   function automatic logic [15:0] udb_crc(input logic [15:0] c, input logic [15:0] d);
      logic [15:0] r;
      logic        fb;
      r = c;
      for (int i = 15; i >= 0; i--) begin
         fb = r[15] ^ d[i];
         r  = {r[14:0], 1'b0} ^ (fb ? `UDB_CRC_POLY : 16'h0000);
      end
      return r;
   endfunction : udb_crc
endpackage : udb_pkg

// File: pkg/udb_if.sv
`timescale 1ns/1ns
`include "udb_params.svh"
// ************************************************************
// burst link between device and host
// ************************************************************
interface udb_if;
   logic        dmarq;
   logic        dmack;
   logic        stop;
   logic        hrl;
   logic        drl_o;
   logic        drl_oe;
   logic        drl;
   logic [15:0] dd_o;
   logic        dd_oe;
   logic [15:0] hd_o;
   logic        hd_oe;
   logic [15:0] data;

   // released lines float to the pull-up level
   assign drl  = drl_oe ? drl_o : `UDB_LINE_IDLE;
   assign data = dd_oe ? dd_o : (hd_oe ? hd_o : `UDB_BUS_IDLE);

   modport dev  (output dmarq, drl_o, drl_oe, dd_o, dd_oe, input dmack, stop, hrl, data);
   modport host (output dmack, stop, hrl, hd_o, hd_oe, input dmarq, drl, data);
endinterface : udb_if

// File: design/udb_device.sv
`timescale 1ns/1ns
// ************************************************************
// burst device end
// ************************************************************
module udb_device (
   input  logic               sys_clk_in,
   input  logic               reset_in,
   input  logic               pccard_mode_in,
   input  udb_pkg::udb_mode_t udma_mode_in,
   input  logic               start_in,
   input  logic               dev_sends_in,
   input  logic               stop_req_in,
   input  logic               pause_in,
   input  logic [15:0]        tx_data_in,
   input  logic               tx_valid_in,
   output logic               tx_ready_out,
   output logic [15:0]        rx_data_out,
   output logic               rx_valid_out,
   output logic               crc_err_out,
   output logic               done_out,
   output logic               busy_out,
   udb_if.dev                 link
);
   import udb_pkg::*;

   // whole state in one register
   udb_dev_st_t s_r;
   udb_dev_st_t s_nxt;
   logic        ak_on;
   logic        rq_on;
   logic        both;
   logic        hedge;
   logic        stop_on;
   logic        want_off;
   logic [7:0]  rp_cyc;
   logic [7:0]  ss_cyc;

   // ************************************************************
   // decoded link conditions
   // ************************************************************
   assign ak_on    = udb_on(pccard_mode_in, 1'b1, s_r.ak2);
   assign rq_on    = udb_on(pccard_mode_in, 1'b0, s_r.rq);
   assign both     = ak_on & rq_on;
   assign stop_on  = both & s_r.sp2;
   assign hedge    = s_r.hl2 ^ s_r.hl3;
   assign want_off = pause_in | stop_req_in;
   assign rp_cyc   = udb_rp_cyc(udma_mode_in);
   assign ss_cyc   = udb_ns2cyc(`UDB_SS_NS);

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      s_nxt     = s_r;
      // two-stage synchronisers on every incoming pin
      s_nxt.ak1 = link.dmack;
      s_nxt.ak2 = s_r.ak1;
      s_nxt.sp1 = link.stop;
      s_nxt.sp2 = s_r.sp1;
      s_nxt.hl1 = link.hrl;
      s_nxt.hl2 = s_r.hl1;
      s_nxt.hl3 = s_r.hl2;
      s_nxt.d1  = link.data;
      s_nxt.d2  = s_r.d1;
      // pulses drop unless set below
      s_nxt.txr  = 1'b0;
      s_nxt.rxv  = 1'b0;
      s_nxt.done = 1'b0;
      // gap counter, saturating
      s_nxt.cnt  = (s_r.cnt == 8'hFF) ? s_r.cnt : s_r.cnt + 8'h01;
      unique case (s_r.st)
         D_IDLE: begin
            // request negated, data bus released
            s_nxt.busy   = 1'b0;
            s_nxt.drl    = `UDB_LINE_IDLE;
            s_nxt.drl_oe = pccard_mode_in;
            s_nxt.dd_oe  = 1'b0;
            s_nxt.rq     = udb_pin(pccard_mode_in, 1'b0, 1'b0);
            if (start_in) begin
               s_nxt.dir  = dev_sends_in;
               s_nxt.rq   = udb_pin(pccard_mode_in, 1'b0, 1'b1);
               s_nxt.busy = 1'b1;
               s_nxt.err  = 1'b0;
               s_nxt.pend = 1'b0;
               s_nxt.crc  = `UDB_CRC_SEED;
               s_nxt.st   = D_REQ;
            end
         end

         D_REQ: begin
            // wait for the host as long as it takes
            if (ak_on && !s_r.sp2) begin
               s_nxt.drl_oe = 1'b1;
               s_nxt.cnt    = 8'h00;
               if (!s_r.dir) begin
                  s_nxt.drl = 1'b0;
                  s_nxt.st  = D_OUT;
               end else if (!s_r.hl2) begin
                  s_nxt.dd_oe = 1'b1;
                  s_nxt.st    = D_IN;
               end
            end
         end

         D_IN: begin
            // latch a word, set it up, then strobe
            if (s_r.pend) begin
               // strobe edge after data setup
               if (s_r.cnt == `UDB_SETUP_CYC) begin
                  s_nxt.drl  = ~s_r.drl;
                  s_nxt.pend = 1'b0;
                  s_nxt.cnt  = 8'h00;
               end
            end else if (stop_on || stop_req_in) begin
               s_nxt.st = D_SS;
            end else if (!s_r.hl2 && s_r.cnt >= `UDB_HALF_CYC && tx_valid_in) begin
               s_nxt.dd   = tx_data_in;
               s_nxt.crc  = udb_crc(s_r.crc, tx_data_in);
               s_nxt.txr  = 1'b1;
               s_nxt.pend = 1'b1;
               s_nxt.cnt  = 8'h00;
            end
         end

         D_SS: begin
            // hold off after the last strobe edge
            if (s_r.cnt >= ss_cyc) begin
               s_nxt.rq    = udb_pin(pccard_mode_in, 1'b0, 1'b0);
               s_nxt.dd_oe = 1'b0;
               s_nxt.st    = D_END;
            end
         end

         D_OUT: begin
            // take a word on either strobe edge, even when paused
            if (both && hedge) begin
               s_nxt.rxd = s_r.d2;
               s_nxt.rxv = 1'b1;
               s_nxt.crc = udb_crc(s_r.crc, s_r.d2);
            end
            // ready follows pause and stop requests
            if (want_off && !s_r.drl) begin
               s_nxt.drl = 1'b1;
               s_nxt.cnt = 8'h00;
            end else if (!want_off && s_r.drl) begin
               s_nxt.drl = 1'b0;
            end
            // end on host stop, or own stop after the pause wait
            if (stop_on) begin
               s_nxt.drl = 1'b1;
               s_nxt.rq  = udb_pin(pccard_mode_in, 1'b0, 1'b0);
               s_nxt.st  = D_END;
            end else if (stop_req_in && s_r.drl && s_r.cnt >= rp_cyc) begin
               s_nxt.rq = udb_pin(pccard_mode_in, 1'b0, 1'b0);
               s_nxt.st = D_END;
            end
         end

         D_END: begin
            s_nxt.drl = `UDB_LINE_IDLE;
            // acknowledge gone: bus holds the host crc word
            if (!ak_on) begin
               s_nxt.err    = s_r.d2 != s_r.crc;
               s_nxt.done   = 1'b1;
               s_nxt.drl_oe = pccard_mode_in;
               s_nxt.st     = D_IDLE;
            end
         end
      endcase
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_r     <= '0;
         s_r.st  <= D_IDLE;
         s_r.drl <= `UDB_LINE_IDLE;
         // control-line synchronisers start at the released pin levels
         s_r.ak1 <= `UDB_LINE_IDLE;
         s_r.ak2 <= `UDB_LINE_IDLE;
         s_r.sp1 <= `UDB_LINE_IDLE;
         s_r.sp2 <= `UDB_LINE_IDLE;
         s_r.hl1 <= `UDB_LINE_IDLE;
         s_r.hl2 <= `UDB_LINE_IDLE;
         s_r.hl3 <= `UDB_LINE_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign tx_ready_out = s_r.txr;
   assign rx_data_out  = s_r.rxd;
   assign rx_valid_out = s_r.rxv;
   assign crc_err_out  = s_r.err;
   assign done_out     = s_r.done;
   assign busy_out     = s_r.busy;

   // link pins straight from the state register
   assign link.dmarq   = s_r.rq;
   assign link.drl_o   = s_r.drl;
   assign link.drl_oe  = s_r.drl_oe;
   assign link.dd_o    = s_r.dd;
   assign link.dd_oe   = s_r.dd_oe;
endmodule : udb_device

// File: design/udb_host.sv
`timescale 1ns/1ns
// ************************************************************
// burst host end
// ************************************************************
module udb_host (
   input  logic               sys_clk_in,
   input  logic               reset_in,
   input  logic               pccard_mode_in,
   input  udb_pkg::udb_mode_t udma_mode_in,
   input  logic               enable_in,
   input  logic               host_sends_in,
   input  logic               stop_req_in,
   input  logic               pause_in,
   input  logic [15:0]        tx_data_in,
   input  logic               tx_valid_in,
   output logic               tx_ready_out,
   output logic [15:0]        rx_data_out,
   output logic               rx_valid_out,
   output logic               done_out,
   output logic               busy_out,
   udb_if.host                link
);
   import udb_pkg::*;

   udb_host_st_t s_r;
   udb_host_st_t s_nxt;
   logic         rq_on;
   logic         ak_on;
   logic         dedge;
   logic         want_off;
   logic [7:0]   rp_cyc;
   logic [7:0]   ss_cyc;

   // ************************************************************
   // decoded link conditions
   // ************************************************************
   assign rq_on    = udb_on(pccard_mode_in, 1'b0, s_r.rq2);
   assign ak_on    = udb_on(pccard_mode_in, 1'b1, s_r.ak);
   assign dedge    = s_r.dl2 ^ s_r.dl3;
   assign want_off = pause_in | stop_req_in;
   assign rp_cyc   = udb_rp_cyc(udma_mode_in);
   assign ss_cyc   = udb_ns2cyc(`UDB_SS_NS);

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      s_nxt      = s_r;
      s_nxt.rq1  = link.dmarq;
      s_nxt.rq2  = s_r.rq1;
      s_nxt.dl1  = link.drl;
      s_nxt.dl2  = s_r.dl1;
      s_nxt.dl3  = s_r.dl2;
      s_nxt.d1   = link.data;
      s_nxt.d2   = s_r.d1;
      s_nxt.txr  = 1'b0;
      s_nxt.rxv  = 1'b0;
      s_nxt.done = 1'b0;
      s_nxt.cnt  = (s_r.cnt == 8'hFF) ? s_r.cnt : s_r.cnt + 8'h01;
      unique case (s_r.st)
         H_IDLE: begin
            s_nxt.busy = 1'b0;
            s_nxt.ak   = udb_pin(pccard_mode_in, 1'b1, 1'b0);
            if (rq_on && enable_in) begin
               s_nxt.ak   = udb_pin(pccard_mode_in, 1'b1, 1'b1);
               s_nxt.dir  = host_sends_in;
               s_nxt.busy = 1'b1;
               s_nxt.pend = 1'b0;
               s_nxt.crc  = `UDB_CRC_SEED;
               s_nxt.cnt  = 8'h00;
               s_nxt.st   = H_ENV;
            end
         end
         H_ENV: begin
            // burst roles start after acknowledge settles
            if (s_r.cnt >= `UDB_ENV_CYC) begin
               s_nxt.stp   = 1'b0;
               s_nxt.hrl   = s_r.dir;
               s_nxt.hd_oe = s_r.dir;
               s_nxt.cnt   = 8'h00;
               s_nxt.st    = s_r.dir ? H_OUT : H_IN;
            end
         end
         H_IN: begin
            // device drives data only while both lines are asserted
            if (rq_on && ak_on && dedge) begin
               s_nxt.rxd = s_r.d2;
               s_nxt.rxv = 1'b1;
               s_nxt.crc = udb_crc(s_r.crc, s_r.d2);
            end
            if (want_off && !s_r.hrl) begin
               s_nxt.hrl = 1'b1;
               s_nxt.cnt = 8'h00;
            end else if (!want_off && s_r.hrl) begin
               s_nxt.hrl = 1'b0;
            end
            if (!rq_on) begin
               s_nxt.stp = 1'b1;
               s_nxt.hrl = 1'b1;
               s_nxt.st  = H_WAIT;
            end else if (stop_req_in && s_r.hrl && s_r.cnt >= rp_cyc) begin
               s_nxt.stp = 1'b1;
               s_nxt.st  = H_WAIT;
            end
         end
         H_OUT: begin
            if (s_r.pend) begin
               if (s_r.cnt == `UDB_SETUP_CYC) begin
                  s_nxt.hrl  = ~s_r.hrl;
                  s_nxt.pend = 1'b0;
                  s_nxt.cnt  = 8'h00;
               end
            end else if (!rq_on || stop_req_in) begin
               s_nxt.st = H_SS;
            end else if (!s_r.dl2 && s_r.cnt >= `UDB_HALF_CYC && tx_valid_in) begin
               s_nxt.hd   = tx_data_in;
               s_nxt.crc  = udb_crc(s_r.crc, tx_data_in);
               s_nxt.txr  = 1'b1;
               s_nxt.pend = 1'b1;
               s_nxt.cnt  = 8'h00;
            end
         end
         H_SS: begin
            if (s_r.cnt >= ss_cyc) begin
               s_nxt.stp = 1'b1;
               s_nxt.st  = H_WAIT;
            end
         end
         H_WAIT: begin
            // no timeout on the request negation
            if (!rq_on) begin
               s_nxt.hd    = s_r.crc;
               s_nxt.hd_oe = 1'b1;
               s_nxt.hrl   = 1'b1;
               s_nxt.cnt   = 8'h00;
               s_nxt.st    = H_CRC;
            end
         end
         H_CRC: begin
            if (s_r.cnt >= `UDB_HOLD_CYC) begin
               s_nxt.ak  = udb_pin(pccard_mode_in, 1'b1, 1'b0);
               s_nxt.cnt = 8'h00;
               s_nxt.st  = H_HOLD;
            end
         end
         H_HOLD: begin
            if (s_r.cnt >= `UDB_HOLD_CYC) begin
               s_nxt.hd_oe = 1'b0;
               s_nxt.done  = 1'b1;
               s_nxt.st    = H_IDLE;
            end
         end
      endcase
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_r     <= '0;
         s_r.st  <= H_IDLE;
         s_r.ak  <= `UDB_LINE_IDLE;
         s_r.stp <= `UDB_LINE_IDLE;
         s_r.hrl <= `UDB_LINE_IDLE;
         s_r.dl1 <= `UDB_LINE_IDLE;
         s_r.dl2 <= `UDB_LINE_IDLE;
         s_r.dl3 <= `UDB_LINE_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign tx_ready_out = s_r.txr;
   assign rx_data_out  = s_r.rxd;
   assign rx_valid_out = s_r.rxv;
   assign done_out     = s_r.done;
   assign busy_out     = s_r.busy;
   assign link.dmack   = s_r.ak;
   assign link.stop    = s_r.stp;
   assign link.hrl     = s_r.hrl;
   assign link.hd_o    = s_r.hd;
   assign link.hd_oe   = s_r.hd_oe;
endmodule : udb_host

// File: bench/udb_link_monitor.sv
`timescale 1ns/1ns
// ************************************************************
// link checker beside the interface
// ************************************************************
module udb_link_monitor (
   input logic               sys_clk_in,
   input logic               reset_in,
   input udb_pkg::udb_mode_t udma_mode_in,
   input logic               dmarq,
   input logic               dmack,
   input logic               stop,
   input logic               hrl,
   input logic               drl_o,
   input logic               drl_oe,
   input logic [15:0]        dd_o,
   input logic               dd_oe,
   input logic [15:0]        hd_o,
   input logic               hd_oe
);
   import udb_pkg::*;

   logic       dprev_r;
   logic       hprev_r;
   logic [7:0] dcnt_r;
   logic [7:0] hcnt_r;

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (reset_in);

   // minimum pause wait in cycles per mode
   function automatic logic [7:0] mon_rp(input udb_mode_t m);
      case (m)
         3'h1: return 8'h10;
         3'h2, 3'h3, 3'h4: return 8'h0D;
         3'h5: return 8'h0B;
         default: return 8'h14;
      endcase
   endfunction : mon_rp

   // first cycle that may no longer carry a strobe edge after ready negation
   function automatic logic [7:0] mon_rfs(input udb_mode_t m);
      case (m)
         3'h1: return 8'h08;
         3'h2, 3'h3, 3'h4: return 8'h07;
         3'h5: return 8'h06;
         default: return 8'h09;
      endcase
   endfunction : mon_rfs

   // cycles since the last change of drl_o and of hrl, saturating
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         dprev_r <= 1'b1;
         hprev_r <= 1'b1;
         dcnt_r  <= 8'hFF;
         hcnt_r  <= 8'hFF;
      end else begin
         dprev_r <= drl_o;
         hprev_r <= hrl;
         dcnt_r  <= (drl_o != dprev_r) ? 8'h00 : dcnt_r + {7'h00, dcnt_r != 8'hFF};
         hcnt_r  <= (hrl != hprev_r) ? 8'h00 : hcnt_r + {7'h00, hcnt_r != 8'hFF};
      end
   end

   a_bus_no_clash: assert property (!(dd_oe && hd_oe))
      else $error("both ends drive the data bus");
   a_dev_drive_burst: assert property (dd_oe |-> !dmack)
      else $error("device drives data outside a burst");
   a_host_drive_burst: assert property ($rose(hd_oe) |-> !dmack)
      else $error("host starts driving data without acknowledge");
   a_dev_strobe_setup: assert property ($changed(drl_o) && dd_oe |-> dd_o == $past(dd_o, 2))
      else $error("device strobe edge without stable word");
   a_host_strobe_setup: assert property ($changed(hrl) && hd_oe && dmarq |->
      !dmack && hd_o == $past(hd_o, 2))
      else $error("host strobe edge without stable word");
   a_final_strobe: assert property ($changed(drl_o) && dd_oe && hrl |->
      hcnt_r < mon_rfs(udma_mode_in))
      else $error("device strobe edge too late after host paused");
   a_dev_end_gap: assert property ($fell(dmarq) && $past(dd_oe) && !stop |-> dcnt_r >= 8'h06)
      else $error("device ends burst too soon after last strobe");
   a_host_pause_wait: assert property ($rose(stop) && dd_oe && dmarq |->
      hcnt_r >= mon_rp(udma_mode_in) - 8'h01)
      else $error("host stop too soon after negating ready");
   a_dev_pause_wait: assert property ($fell(dmarq) && !stop && $past(drl_oe) && !$past(dd_oe) |->
      dcnt_r >= mon_rp(udma_mode_in) - 8'h01)
      else $error("device request negated too soon after ready");
   a_crc_hold: assert property ($rose(dmack) |-> hd_oe && hd_o == $past(hd_o, 3)
      ##1 (hd_oe && $stable(hd_o)) [*2])
      else $error("host crc word not held around acknowledge");
   a_dev_ready_ack: assert property ($fell(drl_o) |-> !dmack)
      else $error("device ready or strobe before acknowledge");
endmodule : udb_link_monitor

// File: bench/udb_bench.sv
`timescale 1ns/1ns
`include "udb_params.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (b)); end end
// ************************************************************
// both burst ends joined, random bursts in all modes
// ************************************************************
module udb_bench;
   import udb_pkg::*;
   logic        sys_clk_in, reset_in, pccard_mode_in, start_in, dev_sends_in, host_sends_in;
   logic        enable_in, d_stop, d_pause, h_stop, h_pause, tx_valid_in, din, ak_prev;
   udb_mode_t   udma_mode_in;
   logic [15:0] tx_data_in, d_rx_data, h_rx_data, crc_seen;
   logic        d_tx_rdy, d_rx_v, crc_err, d_done, d_busy, h_tx_rdy, h_rx_v, h_done, h_busy;
   logic [15:0] wq [0:63];
   logic [15:0] rq [$];
   logic [31:0] r;
   int          seed, mismatches, checks_done, sent, ddone, hdone;

   udb_if udb_if_i ();

   udb_device udb_device_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .pccard_mode_in(pccard_mode_in), .udma_mode_in(udma_mode_in), .start_in(start_in),
      .dev_sends_in(dev_sends_in), .stop_req_in(d_stop), .pause_in(d_pause),
      .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in), .tx_ready_out(d_tx_rdy),
      .rx_data_out(d_rx_data), .rx_valid_out(d_rx_v), .crc_err_out(crc_err),
      .done_out(d_done), .busy_out(d_busy), .link(udb_if_i.dev));

   udb_host udb_host_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .pccard_mode_in(pccard_mode_in), .udma_mode_in(udma_mode_in), .enable_in(enable_in),
      .host_sends_in(host_sends_in), .stop_req_in(h_stop), .pause_in(h_pause),
      .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in), .tx_ready_out(h_tx_rdy),
      .rx_data_out(h_rx_data), .rx_valid_out(h_rx_v), .done_out(h_done), .busy_out(h_busy),
      .link(udb_if_i.host));

   udb_link_monitor udb_link_monitor_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .udma_mode_in(udma_mode_in), .dmarq(udb_if_i.dmarq), .dmack(udb_if_i.dmack),
      .stop(udb_if_i.stop), .hrl(udb_if_i.hrl), .drl_o(udb_if_i.drl_o),
      .drl_oe(udb_if_i.drl_oe), .dd_o(udb_if_i.dd_o), .dd_oe(udb_if_i.dd_oe),
      .hd_o(udb_if_i.hd_o), .hd_oe(udb_if_i.hd_oe));

   // clock
   initial begin
      sys_clk_in = 1'b0;
      forever #4 sys_clk_in = ~sys_clk_in;
   end

   // expected crc over the words handed to the sender
   function automatic logic [15:0] exp_crc(input int cnt);
      logic [15:0] c;
      c = `UDB_CRC_SEED;
      for (int w = 0; w < cnt; w++) begin
         for (int b = 15; b >= 0; b--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ wq[w][b]) ? `UDB_CRC_POLY : 16'h0000);
         end
      end
      return c;
   endfunction : exp_crc

   task report_and_stop;
      $display("checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop

   // a wait that ran out ends the run
   task wait_ok(input int n);
      if (n >= 5000) begin
         mismatches++;
         report_and_stop();
      end
   endtask : wait_ok

   // sender feed, receiver capture, crc and completion watch
   always @(negedge sys_clk_in) begin
      if ((din ? d_tx_rdy : h_tx_rdy) === 1'b1) begin
         sent++;
         tx_data_in = wq[sent[5:0]];
      end
      if ((din ? h_rx_v : d_rx_v) === 1'b1) begin
         rq.push_back(din ? h_rx_data : d_rx_data);
      end
      if (ak_prev === 1'b0 && udb_if_i.dmack === 1'b1) begin
         crc_seen = udb_if_i.data;
      end
      ak_prev = udb_if_i.dmack;
      ddone += int'(d_done === 1'b1);
      hdone += int'(h_done === 1'b1);
   end

   // one burst: direction, terminating end, receiver pause, word count
   task automatic burst(input int idx, input logic d_in, input logic dstop, input logic pz,
                        input int k);
      int n;
      din = d_in;
      sent = 0;
      ddone = 0;
      hdone = 0;
      rq.delete();
      for (n = 0; n < 64; n++) begin
         r = $random(seed);
         wq[n] = r[15:0];
      end
      udma_mode_in = r[18:16];
      pccard_mode_in = idx[3];
      tx_data_in = wq[0];
      tx_valid_in = 1'b1;
      dev_sends_in = d_in;
      host_sends_in = !d_in;
      start_in = 1'b1;
      repeat (1 + 2 * int'(idx == 0)) @(negedge sys_clk_in); // held while busy: ignored
      start_in = 1'b0;
      for (n = 0; n < 5000 && sent < 1; n++) @(negedge sys_clk_in);
      wait_ok(n);
      if (pz) begin
         if (d_in) h_pause = 1'b1; else d_pause = 1'b1;
         repeat (60) @(negedge sys_clk_in);
         h_pause = 1'b0;
         d_pause = 1'b0;
      end
      for (n = 0; n < 5000 && sent < k; n++) @(negedge sys_clk_in);
      wait_ok(n);
      if (dstop) d_stop = 1'b1; else h_stop = 1'b1;
      for (n = 0; n < 5000 && (ddone == 0 || hdone == 0); n++) @(negedge sys_clk_in);
      wait_ok(n);
      d_stop = 1'b0;
      h_stop = 1'b0;
      tx_valid_in = 1'b0;
      repeat (4) @(negedge sys_clk_in);
      `CHK(rq.size(), sent)
      for (n = 0; n < sent; n++) `CHK(rq[n], wq[n])
      `CHK(crc_seen, exp_crc(sent))
      `CHK(crc_err, 1'b0)
      `CHK(ddone, 1)
      `CHK(d_busy, 1'b0)
      `CHK(hdone, 1)
      `CHK(h_busy, 1'b0)
      $display("burst %0d done: in %0d, stop by device %0d, words %0d", idx, d_in, dstop, sent);
   endtask : burst

   // reset, then bursts over both directions, both terminators and pauses
   initial begin
      seed = 32'h8480;
      {pccard_mode_in, start_in, dev_sends_in, host_sends_in, d_stop, d_pause} = 6'h00;
      {h_stop, h_pause, tx_valid_in, din, ak_prev} = 5'h01;
      {mismatches, checks_done, sent, ddone, hdone} = '0;
      udma_mode_in = 3'h0;
      tx_data_in = 16'h0000;
      enable_in = 1'b1;
      reset_in = 1'b1;
      repeat (6) @(negedge sys_clk_in);
      reset_in = 1'b0;
      for (int i = 0; i < 16; i++) begin
         r = $random(seed);
         burst(i, i[0], i[1], i[2], (i < 2) ? 1 : 1 + int'(r[2:0]));
      end
      report_and_stop();
   end
endmodule : udb_bench
